//--- include/aler_pkg.sv
// Shared constants and types for the ambient light event reporter
package aler_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned ALER_CLK_HZ = 50_000_000;
    localparam int unsigned ALER_SAMPLE_MS = 100;
    localparam int unsigned ALER_SAMPLE_CYCLES = ALER_SAMPLE_MS * (ALER_CLK_HZ / 1000);
    localparam int unsigned ALER_MINUTE_S = 60;
    localparam longint unsigned ALER_MINUTE_CYCLES = 64'(ALER_MINUTE_S) * 64'(ALER_CLK_HZ);
    localparam logic [12:0] ALER_MIN_PER_HOUR = 13'h03C;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [4:0] ALER_OFF_CFG_A = 5'h00;
    localparam logic [4:0] ALER_OFF_CFG_B = 5'h04;
    localparam logic [4:0] ALER_OFF_CMD = 5'h08;
    localparam logic [4:0] ALER_OFF_LAST = 5'h0C;
    localparam logic [4:0] ALER_OFF_STATUS = 5'h10;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned ALER_CFGA_MODE_LSB = 0;
    localparam int unsigned ALER_CFGA_PERIOD_LSB = 8;
    localparam int unsigned ALER_CFGA_MARGIN_LSB = 16;
    localparam int unsigned ALER_CFGA_BYTE3_LSB = 24;
    localparam int unsigned ALER_PERIOD_UNIT_BIT = 7;
    localparam int unsigned ALER_LAST_SEEN_BIT = 16;
    localparam int unsigned ALER_LAST_CUR_LSB = 24;

    // ****************************************************************
    // Message and event codes
    // ****************************************************************
    localparam logic [7:0] ALER_MSG_CONFIG = 8'h0B;
    localparam logic [7:0] ALER_MODE_THRESH = 8'h00;
    localparam logic [7:0] ALER_MODE_CHANGE = 8'h01;
    localparam logic [7:0] ALER_EV_PERIODIC = 8'h00;
    localparam logic [7:0] ALER_EV_UPPER = 8'h01;
    localparam logic [7:0] ALER_EV_LOWER = 8'h02;
    localparam logic [7:0] ALER_EV_INC = 8'h03;
    localparam logic [7:0] ALER_EV_DEC = 8'h04;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] ALER_RST_CFG_A = 32'h0000_0000;
    localparam logic [7:0] ALER_RST_CFG_B = 8'hFF;
    localparam logic [7:0] ALER_RST_PERIOD = 8'h00;
    localparam logic [3:0] ALER_RST_MARGIN = 4'h0;
    localparam logic [7:0] ALER_RST_BYTE3 = 8'h00;
    localparam logic [7:0] ALER_RST_BYTE4 = 8'hFF;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic {ALER_THRESHOLD, ALER_CHANGE} aler_mode_t;

    typedef struct packed {
        aler_mode_t mode;
        logic [7:0] period;
        logic [3:0] margin;
        logic [7:0] lowOrInc;
        logic [7:0] highOrDec;
    } aler_cfg_t;

    typedef struct packed {
        logic [7:0] eventCode;
        logic [7:0] level;
    } aler_report_t;

endpackage : aler_pkg

//--- design/aler_event_reporter.sv
// Ambient light event reporter: limit, change and periodic reports
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module aler_event_reporter import aler_pkg::*; #(
    parameter int unsigned SAMPLE_CYCLES = ALER_SAMPLE_CYCLES,
    parameter longint unsigned MINUTE_CYCLES = ALER_MINUTE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Light level pins from the sensor front end
    input wire logic [7:0] lightLevel,
    // Uplink report strobe and payload
    output logic reportValid,
    output aler_report_t reportMsg
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Saturating byte arithmetic, keeps rearm levels inside the scale
    function automatic logic [7:0] satSub(input logic [7:0] a, input logic [3:0] b);
        satSub = (a > {4'h0, b}) ? (a - {4'h0, b}) : 8'h00;
    endfunction : satSub

    function automatic logic [7:0] satAdd(input logic [7:0] a, input logic [3:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {5'h00, b};
        satAdd = s[8] ? 8'hFF : s[7:0];
    endfunction : satAdd

    // Period byte to a length in minutes, zero when disabled
    function automatic logic [12:0] periodMinutes(input logic [7:0] p);
        if (p[ALER_PERIOD_UNIT_BIT]) begin
            periodMinutes = {6'h00, p[6:0]};
        end else begin
            periodMinutes = 13'({6'h00, p[6:0]} * ALER_MIN_PER_HOUR);
        end
    endfunction : periodMinutes

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [31:0] stageA;
    logic [7:0] stageB;
    aler_cfg_t cfg;
    logic [31:0] next_readData;
    logic busWr;
    logic applyCfg;
    logic [7:0] syncA;
    logic [7:0] syncB;
    logic [31:0] sampleCnt;
    logic [7:0] curSample;
    logic newSample;
    logic upArmed;
    logic loArmed;
    logic [7:0] refLevel;
    logic refValid;
    logic [31:0] minuteCnt;
    logic minuteTick;
    logic [12:0] intervalCnt;
    logic [12:0] intervalLen;
    logic periodDue;
    logic periodPending;
    logic evFire;
    logic [7:0] evCode;
    logic sendNow;
    logic reportSeen;

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************

    // A request is served on the edge where waitrequest is already low
    assign busWr = avs_write && !avs_waitrequest;

    // One wait cycle per access so read data come from a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read mux, unmapped offsets read as zero
    always_comb begin
        next_readData = 32'h0000_0000;
        case (avs_address)
            ALER_OFF_CFG_A: next_readData = stageA;
            ALER_OFF_CFG_B: next_readData = {24'h00_0000, stageB};
            ALER_OFF_LAST: begin
                next_readData[15:0] = reportMsg;
                next_readData[ALER_LAST_SEEN_BIT] = reportSeen;
                next_readData[ALER_LAST_CUR_LSB +: 8] = curSample;
            end
            ALER_OFF_STATUS: begin
                next_readData[0] = (cfg.mode == ALER_CHANGE);
                next_readData[1] = upArmed;
                next_readData[2] = loArmed;
                next_readData[3] = periodPending;
                next_readData[4] = refValid;
            end
            default: next_readData = 32'h0000_0000;
        endcase
    end

    // Data captured in the wait cycle and held through the answer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readData;
        end
    end

    // Staging bytes of the configuration message, per byte lane
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stageA <= ALER_RST_CFG_A;
            stageB <= ALER_RST_CFG_B;
        end else if (busWr && avs_address == ALER_OFF_CFG_A) begin
            for (int i = 0; i < 4; i++) begin
                if (avs_byteenable[i]) begin
                    stageA[8*i +: 8] <= avs_writedata[8*i +: 8];
                end
            end
        end else if (busWr && avs_address == ALER_OFF_CFG_B && avs_byteenable[0]) begin
            stageB <= avs_writedata[7:0];
        end
    end

    // Message code 0Bh with a known mode byte commits the staging bytes
    assign applyCfg = busWr && avs_address == ALER_OFF_CMD && avs_byteenable[0]
        && avs_writedata[7:0] == ALER_MSG_CONFIG
        && (stageA[ALER_CFGA_MODE_LSB +: 8] == ALER_MODE_THRESH
        || stageA[ALER_CFGA_MODE_LSB +: 8] == ALER_MODE_CHANGE);

    // Active configuration, replaced whole on commit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg.mode <= ALER_THRESHOLD;
            cfg.period <= ALER_RST_PERIOD;
            cfg.margin <= ALER_RST_MARGIN;
            cfg.lowOrInc <= ALER_RST_BYTE3;
            cfg.highOrDec <= ALER_RST_BYTE4;
        end else if (applyCfg) begin
            cfg.mode <= (stageA[ALER_CFGA_MODE_LSB +: 8] == ALER_MODE_CHANGE)
                ? ALER_CHANGE : ALER_THRESHOLD;
            cfg.period <= stageA[ALER_CFGA_PERIOD_LSB +: 8];
            cfg.margin <= stageA[ALER_CFGA_MARGIN_LSB +: 4];
            cfg.lowOrInc <= stageA[ALER_CFGA_BYTE3_LSB +: 8];
            cfg.highOrDec <= stageB;
        end
    end

    // ****************************************************************
    // Light sampling
    // ****************************************************************

    // Two-stage synchroniser; the level moves slowly against the sample rate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncA <= 8'h00;
            syncB <= 8'h00;
        end else begin
            syncA <= lightLevel;
            syncB <= syncA;
        end
    end

    // Fixed sample interval, each capture marks a new sample
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sampleCnt <= 32'h0000_0000;
            curSample <= 8'h00;
            newSample <= 1'b0;
        end else if (sampleCnt == 32'(SAMPLE_CYCLES - 1)) begin
            sampleCnt <= 32'h0000_0000;
            curSample <= syncB;
            newSample <= 1'b1;
        end else begin
            sampleCnt <= sampleCnt + 32'h0000_0001;
            newSample <= 1'b0;
        end
    end

    // ****************************************************************
    // Event evaluation
    // ****************************************************************

    // Limit and change checks on each new sample; upper wins a tie
    always_comb begin
        evFire = 1'b0;
        evCode = ALER_EV_PERIODIC;
        if (newSample) begin
            case (cfg.mode)
                ALER_THRESHOLD: begin
                    if (upArmed && curSample > cfg.highOrDec) begin
                        evFire = 1'b1;
                        evCode = ALER_EV_UPPER;
                    end else if (loArmed && curSample < cfg.lowOrInc) begin
                        evFire = 1'b1;
                        evCode = ALER_EV_LOWER;
                    end
                end
                ALER_CHANGE: begin
                    if (refValid && cfg.lowOrInc != 8'h00
                        && {1'b0, curSample} >= {1'b0, refLevel} + {1'b0, cfg.lowOrInc}) begin
                        evFire = 1'b1;
                        evCode = ALER_EV_INC;
                    end else if (refValid && cfg.highOrDec != 8'h00
                        && {1'b0, refLevel} >= {1'b0, curSample} + {1'b0, cfg.highOrDec}) begin
                        evFire = 1'b1;
                        evCode = ALER_EV_DEC;
                    end
                end
                default: evFire = 1'b0;
            endcase
        end
    end

    // Events beat a waiting periodic report, which then goes a cycle later
    assign sendNow = (evFire || periodPending) && !applyCfg;

    // Upper limit hysteresis; margin 0 rearms as soon as the reading is back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upArmed <= 1'b1;
        end else if (applyCfg) begin
            upArmed <= 1'b1;
        end else if (sendNow && evFire && evCode == ALER_EV_UPPER) begin
            upArmed <= 1'b0;
        end else if (newSample && curSample <= satSub(cfg.highOrDec, cfg.margin)) begin
            upArmed <= 1'b1;
        end
    end

    // Lower limit hysteresis, mirror of the upper one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loArmed <= 1'b1;
        end else if (applyCfg) begin
            loArmed <= 1'b1;
        end else if (sendNow && evFire && evCode == ALER_EV_LOWER) begin
            loArmed <= 1'b0;
        end else if (newSample && curSample >= satAdd(cfg.lowOrInc, cfg.margin)) begin
            loArmed <= 1'b1;
        end
    end

    // Reference for change mode: the reading of the last report, or the first sample while no reference is held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refLevel <= 8'h00;
            refValid <= 1'b0;
        end else if (applyCfg) begin
            refValid <= 1'b0;
        end else if (sendNow || (newSample && !refValid)) begin
            refLevel <= curSample;
            refValid <= 1'b1;
        end
    end

    // ****************************************************************
    // Periodic reports
    // ****************************************************************

    // Minute base; restarted by a new configuration
    assign minuteTick = (minuteCnt == 32'(MINUTE_CYCLES - 64'd1));

    always_ff @(posedge clk) begin
        if (sys_rst || applyCfg || minuteTick) begin
            minuteCnt <= 32'h0000_0000;
        end else begin
            minuteCnt <= minuteCnt + 32'h0000_0001;
        end
    end

    // Interval length in minutes, zero count disables
    assign intervalLen = periodMinutes(cfg.period);
    assign periodDue = minuteTick && intervalLen != 13'h0000
        && (intervalCnt + 13'h0001) >= intervalLen;

    always_ff @(posedge clk) begin
        if (sys_rst || applyCfg || periodDue) begin
            intervalCnt <= 13'h0000;
        end else if (minuteTick && intervalLen != 13'h0000) begin
            intervalCnt <= intervalCnt + 13'h0001;
        end
    end

    // Pending periodic report; a new due time wins over the clear
    always_ff @(posedge clk) begin
        if (sys_rst || applyCfg) begin
            periodPending <= 1'b0;
        end else if (periodDue) begin
            periodPending <= 1'b1;
        end else if (sendNow && !evFire) begin
            periodPending <= 1'b0;
        end
    end

    // ****************************************************************
    // Report output
    // ****************************************************************

    // Two-byte report, code first and present reading second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reportValid <= 1'b0;
            reportMsg <= '0;
        end else begin
            reportValid <= sendNow;
            if (sendNow) begin
                reportMsg.eventCode <= evFire ? evCode : ALER_EV_PERIODIC;
                reportMsg.level <= curSample;
            end
        end
    end

    // Sticky marker that at least one report has gone out
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reportSeen <= 1'b0;
        end else if (sendNow) begin
            reportSeen <= 1'b1;
        end
    end

endmodule : aler_event_reporter

`default_nettype wire

//--- testbench/aler_checker_sva.sv
// Port-level checker for the ambient light event reporter
`timescale 1ns/100ps
`default_nettype none

module aler_checker import aler_pkg::*; #(
    parameter int unsigned SAMPLE_CYCLES = 8,
    parameter longint unsigned MINUTE_CYCLES = 64'd50
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Light input and uplink
    input wire logic [7:0] lightLevel,
    input wire logic reportValid,
    input wire aler_report_t reportMsg
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_wait_after_req:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after a request");
    a_wait_one_low:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle_high:
        assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    a_reset_quiet:
        assert property ($fell(sys_rst) |-> avs_waitrequest && !reportValid && reportMsg == 16'h0)
        else $error("outputs not at rest after reset");
    a_code_known:
        assert property (reportValid |-> reportMsg.eventCode <= ALER_EV_DEC)
        else $error("report carries an unknown event code");
    a_msg_holds:
        assert property ($changed(reportMsg) |-> reportValid)
        else $error("report payload changed without a report");
    a_unmapped_zero:
        assert property (avs_read && !avs_waitrequest
            && (avs_address == ALER_OFF_CMD || avs_address > ALER_OFF_STATUS)
            |-> avs_readdata == 32'h0)
        else $error("write-only or unmapped offset read non-zero");
    a_last_mirror:
        assert property (avs_read && !avs_waitrequest && avs_address == ALER_OFF_LAST
            |-> avs_readdata[15:0] == $past(reportMsg))
        else $error("last report register differs from the uplink payload");
endmodule : aler_checker

bind aler_event_reporter aler_checker #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .MINUTE_CYCLES(MINUTE_CYCLES)
) u_chk (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lightLevel(lightLevel), .reportValid(reportValid), .reportMsg(reportMsg)
);

`default_nettype wire

//--- testbench/aler_uplink_sink.sv
// Network-side receiver model for uplink reports
`timescale 1ns/100ps
`default_nettype none

module aler_uplink_sink import aler_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Uplink from the sensor
    input wire logic reportValid,
    input wire aler_report_t reportMsg,
    // Tallies for the bench
    output int rxCount,
    output int badCount
);
    // Decode each two-byte report; no back-pressure exists, so every pulse counts
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxCount <= 0;
            badCount <= 0;
        end else if (reportValid === 1'b1) begin
            rxCount <= rxCount + 1;
            if (reportMsg.eventCode > ALER_EV_DEC) begin
                badCount <= badCount + 1;
            end
        end
    end
endmodule : aler_uplink_sink

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the ambient light event reporter
`timescale 1ns/100ps
`default_nettype none

module tb import aler_pkg::*;;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam logic [7:0] NONE = 8'hFF;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] lightLevel = 8'h00;
    logic reportValid;
    aler_report_t reportMsg;
    aler_report_t expMsg;
    aler_report_t expQ[$];
    logic [31:0] rdata;
    logic [31:0] seed = 32'h590859DA;
    logic [7:0] perList [3] = '{8'h00, 8'h80, 8'h01};
    int num_errors = 0;
    int total_checks = 0;
    int pushed = 0;
    int rxCount;
    int badCount;

    // 50 MHz clock
    always #10 clk = ~clk;

    // Short sample and minute counts keep the run brief
    aler_event_reporter #(.SAMPLE_CYCLES(8), .MINUTE_CYCLES(64'd50)) dut (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lightLevel(lightLevel),
        .reportValid(reportValid), .reportMsg(reportMsg)
    );

    // Network side model
    aler_uplink_sink u_sink (
        .clk(clk), .sys_rst(sys_rst), .reportValid(reportValid), .reportMsg(reportMsg),
        .rxCount(rxCount), .badCount(badCount)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // One bus access; trailing edge keeps back-to-back calls from double driving
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (avs_waitrequest !== 1'b0) begin
            check(1'b0, "bus access timed out");
            finish_test();
        end
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    // Stage both config words, then send the config message
    task automatic cfg(input logic [7:0] m, p, input logic [3:0] g, input logic [7:0] b3, b4);
        bus(1'b1, ALER_OFF_CFG_A, {b3, 4'h0, g, p, m});
        bus(1'b1, ALER_OFF_CFG_B, {24'h0, b4});
        bus(1'b1, ALER_OFF_CMD, {24'h0, ALER_MSG_CONFIG});
    endtask : cfg

    task automatic want(input logic [7:0] code, input logic [7:0] v);
        expQ.push_back({code, v});
        pushed++;
    endtask : want

    // New level, then enough time for sync, sampling and report
    task automatic step(input logic [7:0] v, input logic [7:0] code);
        if (code != NONE) begin
            want(code, v);
        end
        lightLevel <= v;
        repeat (30) @(posedge clk);
    endtask : step

    // Monitor: oldest note against each report as it appears
    always @(posedge clk) begin
        if (sys_rst === 1'b0 && reportValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check(1'b0, "report not expected");
            end else begin
                expMsg = expQ.pop_front();
                check(reportMsg === expMsg, "report differs from expected");
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Register reset values, unmapped space, random readback
        bus(1'b0, ALER_OFF_CFG_A, 32'h0);
        check(rdata === 32'h0, "config word A reset value");
        bus(1'b0, ALER_OFF_CFG_B, 32'h0);
        check(rdata[7:0] === 8'hFF, "config word B reset value");
        bus(1'b0, 5'h14, 32'h0);
        check(rdata === 32'h0, "unmapped read not zero");
        seed = lfsr_next(seed);
        bus(1'b1, ALER_OFF_CFG_A, seed);
        bus(1'b0, ALER_OFF_CFG_A, 32'h0);
        check(rdata === seed, "config word A readback");
        // Only lane 1 written, the other lanes keep the random word
        avs_byteenable <= 4'h2;
        bus(1'b1, ALER_OFF_CFG_A, 32'h0);
        avs_byteenable <= 4'hF;
        bus(1'b0, ALER_OFF_CFG_A, 32'h0);
        check(rdata === {seed[31:16], 8'h00, seed[7:0]}, "byte lane write");
        $display("test registers done");
        // Threshold mode, margin 5, limits 50 and 100 inside the scale
        step(8'd70, NONE);
        cfg(ALER_MODE_THRESH, 8'h00, 4'h5, 8'd50, 8'd100);
        step(8'd101, ALER_EV_UPPER);
        step(8'd98, NONE);
        step(8'd101, NONE);
        step(8'd95, NONE);
        step(8'd120, ALER_EV_UPPER);
        step(8'd40, ALER_EV_LOWER);
        step(8'd52, NONE);
        step(8'd55, NONE);
        step(8'd30, ALER_EV_LOWER);
        bus(1'b0, ALER_OFF_LAST, 32'h0);
        check({rdata[31:24], rdata[16:0]} === {8'd30, 1'b1, ALER_EV_LOWER, 8'd30}, "last report");
        $display("test threshold done");
        // Margin zero; commit rearms both limits at once
        want(ALER_EV_LOWER, 8'd30);
        cfg(ALER_MODE_THRESH, 8'h00, 4'h0, 8'd50, 8'd100);
        step(8'd30, NONE);
        step(8'd101, ALER_EV_UPPER);
        step(8'd100, NONE);
        step(8'd101, ALER_EV_UPPER);
        $display("test margin zero done");
        // Change mode, rise 10 and fall 5; first sample only sets the reference
        step(8'd100, NONE);
        cfg(ALER_MODE_CHANGE, 8'h00, 4'h0, 8'd10, 8'd5);
        step(8'd100, NONE);
        step(8'd109, NONE);
        step(8'd110, ALER_EV_INC);
        step(8'd106, NONE);
        step(8'd105, ALER_EV_DEC);
        // Bad mode byte and wrong message code are both ignored
        bus(1'b1, ALER_OFF_CFG_A, 32'h0000_0002);
        bus(1'b1, ALER_OFF_CMD, {24'h0, ALER_MSG_CONFIG});
        bus(1'b1, ALER_OFF_CFG_A, 32'h0);
        bus(1'b1, ALER_OFF_CMD, 32'h0000_000A);
        bus(1'b0, ALER_OFF_STATUS, 32'h0);
        check(rdata[0] === 1'b1, "refused commit changed the mode");
        // Zero steps disable change reports whatever the level does
        cfg(ALER_MODE_CHANGE, 8'h00, 4'h0, 8'd0, 8'd0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            step(seed[7:0], NONE);
        end
        $display("test change done");
        // Periodic kept to a short burst, costly in the field
        step(8'd77, NONE);
        foreach (perList[i]) begin
            cfg(ALER_MODE_THRESH, perList[i], 4'h0, 8'd0, 8'hFF);
            repeat (120) @(posedge clk);
        end
        want(ALER_EV_PERIODIC, 8'd77);
        want(ALER_EV_PERIODIC, 8'd77);
        cfg(ALER_MODE_THRESH, 8'h81, 4'h0, 8'd0, 8'hFF);
        repeat (120) @(posedge clk);
        cfg(ALER_MODE_THRESH, 8'h00, 4'h0, 8'd0, 8'hFF);
        repeat (120) @(posedge clk);
        $display("test periodic done");
        check(expQ.size() == 0, "expected reports missing");
        check(rxCount == pushed, "receiver count differs");
        check(badCount == 0, "receiver saw unknown codes");
        finish_test();
    end
endmodule : tb

`default_nettype wire
